// File: ipb_packet_buffer.sv
// i2c target with ping-pong receive and transmit packet buffers, crc check
// and the configuration register bank behind them.
// assumes scl/sda arrive asynchronously; sda is open drain, resolved outside.
`default_nettype none

module ipb_packet_buffer #(
  parameter logic [6:0] TARGET_ADDR = 7'h60
) (
  input  wire logic                       mclk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe_o,
  output logic [1:0]                      rx_pending_o,
  output logic [1:0]                      tx_pending_o,
  output logic                            crc_error_o,
  output logic [ipb_pkg::NUM_REGS*32-1:0] cfg_flat_o
);

  if (TARGET_ADDR == 7'h00) begin : g_chk
    $error("target address zero collides with the general call");
  end

  typedef enum logic [2:0] {
    BS_IDLE, BS_ADDR, BS_ACK_WAIT, BS_ACK, BS_RX, BS_TX, BS_TXACK, BS_SKIP
  } ipb_bus_state_t;

  typedef enum logic {PS_IDLE, PS_CRC} ipb_parse_state_t;

  function automatic logic [3:0] len_bytes(input logic [1:0] code);
    case (code)
      ipb_pkg::LEN_CODE_16: len_bytes = ipb_pkg::BYTES_16;
      ipb_pkg::LEN_CODE_32: len_bytes = ipb_pkg::BYTES_32;
      default:              len_bytes = ipb_pkg::BYTES_64;
    endcase
  endfunction

  function automatic logic [7:0] byte_of(input logic [63:0] d, input logic [3:0] idx);
    byte_of = d[{idx[2:0], 3'b000} +: 8];
  endfunction

  function automatic logic [5:0] reg_find(input logic [19:0] a);
    reg_find = 6'h00;
    for (int i = 0; i < ipb_pkg::NUM_REGS; i++) begin
      if (a == ipb_pkg::REG_OFFSET[i]) begin
        reg_find = {1'b1, 5'(i)};
      end
    end
  endfunction

  // ************************************************************
  // pin synchronisers and bus conditions
  // ************************************************************
  logic scl_meta_reg, scl_s_reg, scl_d_reg;
  logic sda_meta_reg, sda_s_reg, sda_d_reg;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scl_meta_reg <= 1'b1;
      scl_s_reg    <= 1'b1;
      scl_d_reg    <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_s_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_meta_reg <= scl_i;
      scl_s_reg    <= scl_meta_reg;
      scl_d_reg    <= scl_s_reg;
      sda_meta_reg <= sda_i;
      sda_s_reg    <= sda_meta_reg;
      sda_d_reg    <= sda_s_reg;
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise   = scl_s_reg & ~scl_d_reg;
  assign scl_fall   = ~scl_s_reg & scl_d_reg;
  assign start_cond = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign stop_cond  = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

  // ************************************************************
  // buffer state
  // ************************************************************
  ipb_bus_state_t   bus_state;
  ipb_parse_state_t ps_state;
  logic [2:0]  bit_cnt, tbit;
  logic [7:0]  shreg, rx_crc_reg, pcrc_reg;
  logic        sda_oe_reg, ack_reg, read_reg, pkt_open;
  logic [3:0]  pkt_idx, tx_idx, pk_reg;
  logic        rx_wr_ptr, rx_rd_ptr, tx_wr_ptr, tx_rd_ptr;
  logic [1:0]  rx_valid, tx_valid;
  logic [23:0] rxb_cw   [2];
  logic [63:0] rxb_data [2];
  logic [7:0]  rxb_crc  [2];
  logic [7:0]  rxb_crc4 [2];
  logic [3:0]  rxb_nbytes [2];
  logic [63:0] txb_data [2];
  logic [3:0]  txb_nbytes [2];
  logic [7:0]  txb_crc  [2];
  logic [1:0]  txb_crc_en;
  logic [31:0] cfg_reg  [ipb_pkg::NUM_REGS];

  logic [7:0] rx_byte, tx_byte, rx_crc_in, rx_crc_next, p_byte, pcrc_next;
  logic       byte_end, addr_end, data_end, tx_done, rx_commit, rx_release, tx_fill;
  logic       addr_match, tx_last;

  assign rx_byte    = {shreg[6:0], sda_s_reg};
  assign byte_end   = scl_rise && bit_cnt == 3'h7;
  assign addr_end   = byte_end && bus_state == BS_ADDR;
  assign data_end   = byte_end && bus_state == BS_RX && pkt_open;
  assign addr_match = rx_byte[7:1] == TARGET_ADDR;
  assign rx_crc_in  = (bus_state == BS_ADDR) ? ipb_pkg::CRC_INIT : rx_crc_reg;
  assign rx_commit  = (start_cond | stop_cond) && pkt_open && pkt_idx >= ipb_pkg::HDR_BYTES;
  assign tx_last    = tx_idx == txb_nbytes[tx_rd_ptr] - 4'h1;
  assign tx_done    = scl_rise && bus_state == BS_TXACK && tx_last;
  // a data byte index past the payload sends the crc byte
  assign tx_byte    = (tx_idx < txb_nbytes[tx_rd_ptr] - {3'h0, txb_crc_en[tx_rd_ptr]})
                    ? byte_of(txb_data[tx_rd_ptr], tx_idx) : txb_crc[tx_rd_ptr];

  ipb_crc8 u_rx_crc (
    .crc_i  (rx_crc_in),
    .data_i (rx_byte),
    .crc_o  (rx_crc_next)
  );

  // ************************************************************
  // i2c target engine; capture runs regardless of the parser
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bus_state  <= BS_IDLE;
      bit_cnt    <= 3'h0;
      tbit       <= 3'h0;
      shreg      <= 8'h00;
      sda_oe_reg <= 1'b0;
      ack_reg    <= 1'b0;
      read_reg   <= 1'b0;
      pkt_open   <= 1'b0;
      pkt_idx    <= 4'h0;
      tx_idx     <= 4'h0;
      rx_crc_reg <= ipb_pkg::CRC_INIT;
      rx_wr_ptr  <= 1'b0;
    end else if (start_cond || stop_cond) begin
      sda_oe_reg <= 1'b0;
      bit_cnt    <= 3'h0;
      bus_state  <= start_cond ? BS_ADDR : BS_IDLE;
      pkt_open   <= 1'b0;
      if (rx_commit) begin
        rx_wr_ptr <= ~rx_wr_ptr;
      end
    end else begin
      case (bus_state)
        BS_ADDR, BS_RX: begin
          if (scl_rise) begin
            shreg   <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
          end
          if (addr_end) begin
            read_reg  <= rx_byte[0];
            tx_idx    <= 4'h0;
            bus_state <= BS_ACK_WAIT;
            if (rx_byte[0]) begin
              ack_reg <= addr_match && tx_valid[tx_rd_ptr];
            end else begin
              ack_reg <= addr_match && !rx_valid[rx_wr_ptr];
              if (addr_match && !rx_valid[rx_wr_ptr]) begin
                pkt_open   <= 1'b1;
                pkt_idx    <= ipb_pkg::CW_FIRST;
                rx_crc_reg <= rx_crc_next;
              end
            end
          end else if (byte_end && bus_state == BS_RX) begin
            ack_reg    <= 1'b1;
            bus_state  <= BS_ACK_WAIT;
            rx_crc_reg <= rx_crc_next;
            if (pkt_idx != ipb_pkg::IDX_SAT) begin
              pkt_idx <= pkt_idx + 4'h1;
            end
          end
        end
        BS_ACK_WAIT: begin
          if (scl_fall) begin
            sda_oe_reg <= ack_reg;
            bus_state  <= ack_reg ? BS_ACK : BS_SKIP;
          end
        end
        BS_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            tbit    <= 3'h0;
            if (read_reg) begin
              sda_oe_reg <= ~tx_byte[7];
              bus_state  <= BS_TX;
            end else begin
              sda_oe_reg <= 1'b0;
              bus_state  <= BS_RX;
            end
          end
        end
        BS_TX: begin
          if (scl_fall) begin
            if (tbit == 3'h7) begin
              sda_oe_reg <= 1'b0;
              bus_state  <= BS_TXACK;
            end else begin
              tbit       <= tbit + 3'h1;
              sda_oe_reg <= ~tx_byte[3'h6 - tbit];
            end
          end
        end
        BS_TXACK: begin
          if (scl_rise) begin
            if (tx_last || sda_s_reg) begin
              bus_state <= BS_SKIP;
            end else begin
              tx_idx    <= tx_idx + 4'h1;
              bus_state <= BS_ACK;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // receive buffer contents
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      for (int b = 0; b < 2; b++) begin
        rxb_cw[b]     <= 24'h000000;
        rxb_data[b]   <= 64'h0;
        rxb_crc[b]    <= ipb_pkg::CRC_INIT;
        rxb_crc4[b]   <= ipb_pkg::CRC_INIT;
        rxb_nbytes[b] <= 4'h0;
      end
    end else if (addr_end && addr_match && !rx_byte[0] && !rx_valid[rx_wr_ptr]) begin
      rxb_cw[rx_wr_ptr]     <= 24'h000000;
      rxb_data[rx_wr_ptr]   <= 64'h0;
      rxb_nbytes[rx_wr_ptr] <= ipb_pkg::CW_FIRST;
    end else if (data_end) begin
      rxb_crc[rx_wr_ptr] <= rx_crc_next;
      if (pkt_idx != ipb_pkg::IDX_SAT) begin
        rxb_nbytes[rx_wr_ptr] <= pkt_idx + 4'h1;
      end
      if (pkt_idx < ipb_pkg::DATA_FIRST) begin
        rxb_cw[rx_wr_ptr] <= {rxb_cw[rx_wr_ptr][15:0], rx_byte};
      end else if (pkt_idx <= ipb_pkg::DATA_LAST) begin
        rxb_data[rx_wr_ptr][{3'(pkt_idx - ipb_pkg::DATA_FIRST), 3'b000} +: 8] <= rx_byte;
      end
      if (pkt_idx == ipb_pkg::HDR_BYTES - 4'h1) begin
        rxb_crc4[rx_wr_ptr] <= rx_crc_next;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_valid <= 2'b00;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (rx_release && rx_rd_ptr == 1'(b)) begin
          rx_valid[b] <= 1'b0;
        end
        if (rx_commit && rx_wr_ptr == 1'(b)) begin
          rx_valid[b] <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // parser: writes registers, prepares read results
  // ************************************************************
  logic [23:0] cw;
  logic [3:0]  lb, expect_n;
  logic        crc_en, wr_ok;
  logic [5:0]  f0, f1;
  logic [31:0] rd0, rd1;
  logic [19:0] addr0, addr1;

  assign cw       = rxb_cw[rx_rd_ptr];
  assign crc_en   = cw[ipb_pkg::CW_CRC_EN_BIT];
  assign lb       = len_bytes(cw[ipb_pkg::CW_LEN_HI:ipb_pkg::CW_LEN_LO]);
  assign expect_n = ipb_pkg::HDR_BYTES + lb + {3'h0, crc_en};
  assign addr0    = cw[ipb_pkg::CW_ADDR_HI:0];
  assign addr1    = addr0 + ipb_pkg::ADDR_STEP;
  assign f0       = reg_find(addr0);
  assign f1       = reg_find(addr1);
  assign rd0      = f0[5] ? cfg_reg[f0[4:0]] : 32'h0;
  assign rd1      = (f1[5] && lb == ipb_pkg::BYTES_64) ? cfg_reg[f1[4:0]] : 32'h0;
  assign wr_ok    = rxb_nbytes[rx_rd_ptr] == expect_n &&
                    (!crc_en || rxb_crc[rx_rd_ptr] == ipb_pkg::CRC_RESIDUE);

  logic do_write, wait_tx;
  assign wait_tx    = tx_valid[tx_wr_ptr];
  assign do_write   = ps_state == PS_IDLE && rx_valid[rx_rd_ptr] && !cw[ipb_pkg::CW_DIR_BIT];
  assign tx_fill    = ps_state == PS_CRC && pk_reg == txb_nbytes[tx_wr_ptr] - {3'h0, crc_en};
  assign rx_release = do_write || tx_fill;
  assign p_byte     = (pk_reg == 4'h0) ? {TARGET_ADDR, 1'b1}
                                       : byte_of(txb_data[tx_wr_ptr], pk_reg - 4'h1);

  ipb_crc8 u_tx_crc (
    .crc_i  (pcrc_reg),
    .data_i (p_byte),
    .crc_o  (pcrc_next)
  );

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ps_state    <= PS_IDLE;
      pk_reg      <= 4'h0;
      pcrc_reg    <= ipb_pkg::CRC_INIT;
      rx_rd_ptr   <= 1'b0;
      tx_wr_ptr   <= 1'b0;
      crc_error_o <= 1'b0;
      txb_crc_en  <= 2'b00;
      for (int b = 0; b < 2; b++) begin
        txb_data[b]   <= 64'h0;
        txb_nbytes[b] <= 4'h0;
        txb_crc[b]    <= ipb_pkg::CRC_INIT;
      end
    end else begin
      crc_error_o <= do_write && crc_en && rxb_crc[rx_rd_ptr] != ipb_pkg::CRC_RESIDUE;
      if (rx_release) begin
        rx_rd_ptr <= ~rx_rd_ptr;
      end
      case (ps_state)
        PS_IDLE: begin
          if (rx_valid[rx_rd_ptr] && cw[ipb_pkg::CW_DIR_BIT] && !wait_tx) begin
            txb_data[tx_wr_ptr]   <= {rd1, lb == ipb_pkg::BYTES_16 ? {16'h0, rd0[15:0]} : rd0};
            txb_nbytes[tx_wr_ptr] <= lb + {3'h0, crc_en};
            txb_crc_en[tx_wr_ptr] <= crc_en;
            pcrc_reg              <= rxb_crc4[rx_rd_ptr];
            pk_reg                <= 4'h0;
            ps_state              <= PS_CRC;
          end
        end
        PS_CRC: begin
          pcrc_reg <= pcrc_next;
          pk_reg   <= pk_reg + 4'h1;
          if (tx_fill) begin
            txb_crc[tx_wr_ptr] <= pcrc_next;
            tx_wr_ptr          <= ~tx_wr_ptr;
            ps_state           <= PS_IDLE;
          end
        end
        default: ps_state <= PS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_valid  <= 2'b00;
      tx_rd_ptr <= 1'b0;
    end else begin
      if (tx_done) begin
        tx_valid[tx_rd_ptr] <= 1'b0;
        tx_rd_ptr           <= ~tx_rd_ptr;
      end
      if (tx_fill) begin
        tx_valid[tx_wr_ptr] <= 1'b1;
      end
    end
  end

  // ************************************************************
  // configuration registers; unmapped offsets take no write
  // ************************************************************
  logic [31:0] wr0;
  assign wr0 = (lb == ipb_pkg::BYTES_16)
             ? {rd0[31:16], rxb_data[rx_rd_ptr][15:0]} : rxb_data[rx_rd_ptr][31:0];

  for (genvar r = 0; r < ipb_pkg::NUM_REGS; r++) begin : g_cfg
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        cfg_reg[r] <= ipb_pkg::REG_RESET[r];
      end else if (do_write && wr_ok) begin
        if (f0[5] && f0[4:0] == 5'(r)) begin
          cfg_reg[r] <= wr0;
        end
        if (f1[5] && f1[4:0] == 5'(r) && lb == ipb_pkg::BYTES_64) begin
          cfg_reg[r] <= rxb_data[rx_rd_ptr][63:32];
        end
      end
    end
    assign cfg_flat_o[r*32 +: 32] = cfg_reg[r];
  end

  assign sda_o        = 1'b0;
  assign sda_oe_o     = sda_oe_reg;
  assign rx_pending_o = rx_valid;
  assign tx_pending_o = tx_valid;

endmodule

`default_nettype wire

// File: ipb_pkg.sv
// constants for the i2c packet buffer with crc check
// assumes a single clock domain; the i2c pins are synchronised in the top module
`default_nettype none

package ipb_pkg;

  // ************************************************************
  // configuration register map
  // ************************************************************
  localparam int          NUM_REGS  = 17;
  localparam int          ADDR_W    = 20;
  localparam logic [19:0] ADDR_STEP = 20'h00002;

  localparam logic [19:0] REG_OFFSET [NUM_REGS] = '{
    20'h00080, 20'h00082, 20'h00084, 20'h00086, 20'h00088, 20'h0008a,
    20'h0008c, 20'h0008e, 20'h00090, 20'h00096, 20'h00098, 20'h0009a,
    20'h0009c, 20'h0009e, 20'h000a0, 20'h000a2, 20'h000a4};

  // last six have an undefined reset; they start at zero here
  localparam logic [31:0] REG_RESET [NUM_REGS] = '{
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h000000a0, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000};

  // ************************************************************
  // control word layout
  // ************************************************************
  localparam int CW_DIR_BIT    = 23;
  localparam int CW_CRC_EN_BIT = 22;
  localparam int CW_LEN_HI     = 21;
  localparam int CW_LEN_LO     = 20;
  localparam int CW_ADDR_HI    = 19;

  localparam logic [1:0] LEN_CODE_16 = 2'h0;
  localparam logic [1:0] LEN_CODE_32 = 2'h1;

  // ************************************************************
  // packet framing and crc
  // ************************************************************
  localparam logic [3:0] HDR_BYTES   = 4'h4;
  localparam logic [3:0] CW_FIRST    = 4'h1;
  localparam logic [3:0] DATA_FIRST  = 4'h4;
  localparam logic [3:0] DATA_LAST   = 4'hb;
  localparam logic [3:0] BYTES_16    = 4'h2;
  localparam logic [3:0] BYTES_32    = 4'h4;
  localparam logic [3:0] BYTES_64    = 4'h8;
  localparam logic [3:0] IDX_SAT     = 4'hf;
  localparam logic [7:0] CRC_POLY    = 8'h07;
  localparam logic [7:0] CRC_INIT    = 8'h00;
  localparam logic [7:0] CRC_RESIDUE = 8'h00;

endpackage

`default_nettype wire

// File: ipb_crc8.sv
// one-byte step of the packet crc, msb first, no reflection
// assumes the caller holds the running value in its own register
`default_nettype none

module ipb_crc8 (
  input  wire logic [7:0] crc_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] crc_o
);

  always_comb begin
    logic [7:0] c;
    c = crc_i;
    for (int i = 7; i >= 0; i--) begin
      if (c[7] ^ data_i[i]) begin
        c = {c[6:0], 1'b0} ^ ipb_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_o = c;
  end

endmodule

`default_nettype wire

// File: ipb_packet_buffer_properties.sv
// bound checker for the i2c packet buffer top module
// assumes one clock domain and a synchronous active-low reset
`default_nettype none

module ipb_packet_buffer_properties (
  input wire logic                            mclk_i,
  input wire logic                            rst_n_i,
  input wire logic                            scl_i,
  input wire logic                            sda_i,
  input wire logic                            sda_o,
  input wire logic                            sda_oe_o,
  input wire logic [1:0]                      rx_pending_o,
  input wire logic [1:0]                      tx_pending_o,
  input wire logic                            crc_error_o,
  input wire logic [ipb_pkg::NUM_REGS*32-1:0] cfg_flat_o
);
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ********
  // properties
  // ********
  a_reset_empty: assert property (disable iff (1'h0)
    !rst_n_i |=> !sda_oe_o && !crc_error_o && rx_pending_o == 2'h0 && tx_pending_o == 2'h0)
    else $error("state not empty after reset");
  a_pin_low_only: assert property (sda_o == 1'h0)
    else $error("data pin driven high");
  a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("data pin moved while clock high");
  a_err_one_cycle: assert property (crc_error_o |=> !crc_error_o)
    else $error("crc error longer than one cycle");
  a_cfg_from_buffer: assert property (!$stable(cfg_flat_o) |-> $past(rx_pending_o) != 2'h0)
    else $error("config changed with no buffered packet");
  a_tx_fill_from_rx: assert property (
    $rose(tx_pending_o[0]) || $rose(tx_pending_o[1]) |-> $past(rx_pending_o) != 2'h0)
    else $error("transmit buffer filled with no request");
  a_tx_free_scl: assert property (
    $fell(tx_pending_o[0]) || $fell(tx_pending_o[1]) |-> $past(scl_i, 2))
    else $error("transmit buffer freed off the bus clock");
  a_rx_release: assert property (
    $rose(rx_pending_o[0]) && tx_pending_o != 2'h3 |-> ##[1:40] !rx_pending_o[0])
    else $error("receive buffer never released");
endmodule

bind ipb_packet_buffer ipb_packet_buffer_properties u_props (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .rx_pending_o(rx_pending_o), .tx_pending_o(tx_pending_o),
  .crc_error_o(crc_error_o), .cfg_flat_o(cfg_flat_o));

`default_nettype wire

// File: ipb_i2c_ctrl_model.sv
// i2c controller model standing on the far side of the packet buffer
// assumes the bench wires sda as wired-and with a pull-up
`default_nettype none

module ipb_i2c_ctrl_model (
  input  wire logic       mclk_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            sda_o,
  output logic            byte_valid_o,
  output logic      [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
    byte_valid_o = 1'h0;
    byte_o = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // ********
  // bus conditions
  // ********
  // scl stands still between frames; sda moves a few cycles after scl falls, or while scl is high for start and stop
  task automatic start_cond();
    tick(4);
    sda_o = 1'h1;
    tick(12);
    scl_o = 1'h1;
    tick(16);
    sda_o = 1'h0;
    tick(16);
    scl_o = 1'h0;
  endtask

  task automatic stop_cond();
    tick(4);
    sda_o = 1'h0;
    tick(12);
    scl_o = 1'h1;
    tick(16);
    sda_o = 1'h1;
    tick(16);
  endtask

  // write: drive tx, sample ack; read: release bits, tx[0] is the ack level
  task automatic xfer(input logic [7:0] tx, input logic rd, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= -1; i--) begin
      tick(4);
      sda_o = (i < 0) ? (rd ? tx[0] : 1'h1) : (rd ? 1'h1 : tx[i]);
      tick(12);
      scl_o = 1'h1;
      tick(14);
      if (i >= 0)
        rx[i] = sda_i;
      else
        ack = ~sda_i;
      tick(2);
      scl_o = 1'h0;
    end
    if (rd) begin
      byte_o = rx;
      byte_valid_o = 1'h1;
      tick(1);
      byte_valid_o = 1'h0;
    end
  endtask
endmodule

`default_nettype wire

// File: test_i2c_packet_buffer_crc.sv
// self-checking bench for the i2c packet buffer with crc check
// assumes the controller model and the bound checker are compiled before it
`default_nettype none

module test_i2c_packet_buffer_crc;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] TADDR = 7'h60;

  logic                            mclk_i = 1'h0;
  logic                            rst_n_i = 1'h0;
  logic                            scl, ctl_sda, bval, sda_o, sda_oe_o, crc_error_o;
  logic [7:0]                      bdat;
  logic [1:0]                      rx_pending_o, tx_pending_o;
  logic [ipb_pkg::NUM_REGS*32-1:0] cfg_flat_o;
  logic [31:0]                     shadow [ipb_pkg::NUM_REGS];
  logic [7:0]                      exp_q [$];
  logic [71:0]                     pend_q [$];
  int                              pend_n [$];
  int                              err_count = 0;
  int                              samples_checked = 0;
  int                              cyc = 0;
  logic                            err_seen = 1'h0;
  wire                             sda_w = ctl_sda & ~sda_oe_o;

  always #2 mclk_i = ~mclk_i;

  ipb_i2c_ctrl_model u_ctrl (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(ctl_sda),
    .byte_valid_o(bval), .byte_o(bdat));
  ipb_packet_buffer #(.TARGET_ADDR(TADDR)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .rx_pending_o(rx_pending_o), .tx_pending_o(tx_pending_o),
    .crc_error_o(crc_error_o), .cfg_flat_o(cfg_flat_o));

  // ********
  // checking
  // ********
  task automatic give_verdict();
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t read byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic compare_stat(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cfg();
    for (int i = 0; i < ipb_pkg::NUM_REGS; i++)
      compare_stat(cfg_flat_o[i*32 +: 32], shadow[i]);
  endtask

  // read bytes are compared in arrival order; also the hang limit
  always @(posedge mclk_i) begin
    cyc++;
    if (bval === 1'h1)
      compare_byte(bdat, exp_q.pop_front());
    if (crc_error_o === 1'h1)
      err_seen = 1'h1;
    if (cyc == 90000) begin
      err_count++;
      give_verdict();
    end
  end

  // ********
  // packet tasks
  // ********
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'h0} ^ 8'h07) : {r[6:0], 1'h0};
    return r;
  endfunction

  function automatic int nb(input logic [1:0] len);
    return (len == 2'h0) ? 2 : (len == 2'h1) ? 4 : 8;
  endfunction

  task automatic put(input logic [7:0] b, inout logic [7:0] c, output logic ack);
    logic [7:0] unused;
    u_ctrl.xfer(b, 1'h0, unused, ack);
    c = crc_step(c, b);
  endtask

  task automatic header(input logic rd, input int r, input logic [1:0] len,
                        output logic [7:0] c, output logic ack);
    logic [23:0] cw;
    logic        a;
    cw = {rd, 1'h1, len, ipb_pkg::REG_OFFSET[r]};
    c = 8'h00;
    u_ctrl.start_cond();
    put({TADDR, 1'h0}, c, ack);
    for (int i = 2; i >= 0; i--)
      put(cw[i*8 +: 8], c, a);
  endtask

  task automatic wr_pkt(input int r, input logic [1:0] len, input logic [63:0] d,
                        input logic bad);
    logic [7:0] c;
    logic       ack;
    header(1'h0, r, len, c, ack);
    for (int i = 0; i < nb(len); i++)
      put(d[i*8 +: 8], c, ack);
    put(c ^ {7'h00, bad}, c, ack);
    u_ctrl.stop_cond();
    if (!bad && len == 2'h0)
      shadow[r][15:0] = d[15:0];
    if (!bad && len != 2'h0)
      shadow[r] = d[31:0];
    if (!bad && len == 2'h2)
      shadow[r+1] = d[63:32];
    u_ctrl.tick(20);
    chk_cfg();
  endtask

  task automatic rd_req(input int r, input logic [1:0] len);
    logic [7:0]  c;
    logic [71:0] e;
    logic        ack;
    header(1'h1, r, len, c, ack);
    u_ctrl.stop_cond();
    compare_stat({31'h0, ack}, 32'h1);
    e = {8'h00, shadow[r+1], shadow[r]};
    c = crc_step(c, {TADDR, 1'h1});
    for (int i = 0; i < nb(len); i++)
      c = crc_step(c, e[i*8 +: 8]);
    e[nb(len)*8 +: 8] = c;
    pend_q.push_back(e);
    pend_n.push_back(nb(len) + 1);
    u_ctrl.tick(40);
  endtask

  task automatic rd_get(input int n);
    logic [7:0] b;
    logic       ack;
    for (int t = 0; t < 20; t++) begin
      u_ctrl.start_cond();
      u_ctrl.xfer({TADDR, 1'h1}, 1'h0, b, ack);
      if (ack === 1'h1) begin
        for (int i = 0; i < n; i++) begin
          exp_q.push_back(pend_q[0][i*8 +: 8]);
          u_ctrl.xfer({7'h00, i == n - 1}, 1'h1, b, ack);
        end
        u_ctrl.stop_cond();
        if (n == pend_n[0]) begin
          pend_q.delete(0);
          pend_n.delete(0);
        end
        return;
      end
      u_ctrl.stop_cond();
      u_ctrl.tick(60);
    end
    compare_stat(32'h0, 32'h1);
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    logic [7:0] c;
    logic       ack;
    c = 8'($urandom(26));
    for (int i = 0; i < ipb_pkg::NUM_REGS; i++)
      shadow[i] = ipb_pkg::REG_RESET[i];
    repeat (8) @(posedge mclk_i);
    #1;
    rst_n_i = 1'h1;
    u_ctrl.tick(4);
    compare_stat({28'h0, rx_pending_o, tx_pending_o}, 32'h0);
    chk_cfg();
    // only mapped offsets, pairs kept inside the map
    for (int k = 0; k < 3; k++)
      wr_pkt($urandom_range(7, 0), 2'(k), {$urandom, $urandom}, 1'h0);
    wr_pkt($urandom_range(7, 0), 2'h1, {$urandom, $urandom}, 1'h1);
    compare_stat({31'h0, err_seen}, 32'h1);
    rd_req($urandom_range(7, 0), 2'h1);
    rd_req($urandom_range(7, 0), 2'h2);
    compare_stat({30'h0, tx_pending_o}, 32'h3);
    rd_req($urandom_range(7, 0), 2'h0);
    rd_req($urandom_range(7, 0), 2'h1);
    compare_stat({30'h0, rx_pending_o}, 32'h3);
    header(1'h0, 1, 2'h1, c, ack);
    u_ctrl.stop_cond();
    compare_stat({31'h0, ack}, 32'h0);
    rd_get(2);
    for (int k = 0; k < 4; k++)
      rd_get(pend_n[0]);
    compare_stat({28'h0, rx_pending_o, tx_pending_o}, 32'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
